// [rtl/gyro_sample_fifo_control.sv]
// Operation
// [R1] Status byte reads the same at the general and FIFO status address.
// [R2] Entering Active from Standby or Ready clears FIFO status and event.
// [R3] Overflow sets on a sample arriving at count 32, clears below 32.
// [R4] Watermark flag high while count is at or above the watermark.
// [R5] Six-bit count of stored samples; zero means empty.
// [R6] Mode 00 disabled, 01 circular, 1x stop.
// [R7] Circular mode when full: oldest sample dropped, new one stored.
// [R8] Stop mode when full: new samples refused, contents kept.
// [R9] Host disables the FIFO before switching circular and stop.
// [R10] Disabled mode empties the FIFO and clears the watermark flag.
// [R11] A watermark setting of zero never raises the watermark flag.
// [R12] Reaching the watermark never halts sample storage.
// [R13] Host changes FIFO setup only in Standby.
// [R14] One sample pushed per output data rate period.
// [R15] Event flag is overflow OR watermark.
// [R16] Five-bit count of rate periods since event; zeroed when both fall.
// [R17] Interrupt source high while event set and FIFO interrupt enabled.
// [R18] Reading a full three-axis sample pops the oldest and decrements count.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "gyro_fifo_cfg.svh"

module gyro_sample_fifo_control #(
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int ODR_BASE_CYCLES = `CLK_HZ / `ODR_MAX_HZ
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire gyro_fifo_pkg::sample_t sample_in,
    output logic queue_interrupt_source,
    output logic irq
);

    localparam int PW = $clog2(DEPTH);
    localparam logic [5:0] FULL = 6'(DEPTH);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic gyro_fifo_pkg::fifo_mode_t decode_fifo_mode(
        input logic [1:0] f);
        return f[1] ? gyro_fifo_pkg::FIFO_STOP
            : f[0] ? gyro_fifo_pkg::FIFO_CIRCULAR : gyro_fifo_pkg::FIFO_OFF;
    endfunction : decode_fifo_mode

    function automatic gyro_fifo_pkg::sys_mode_t decode_sys_mode(
        input logic [1:0] f);
        return f[1] ? gyro_fifo_pkg::SYS_ACTIVE
            : f[0] ? gyro_fifo_pkg::SYS_READY : gyro_fifo_pkg::SYS_STANDBY;
    endfunction : decode_sys_mode

    function automatic logic [7:0] status_byte(input logic ovf,
        input logic wmk, input logic [5:0] cnt);
        return {ovf, wmk, cnt};
    endfunction : status_byte

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    gyro_fifo_pkg::sample_t mem [DEPTH];
    gyro_fifo_pkg::bus_phase_t dphase, next_dphase;
    logic [7:0] setup, next_setup;
    logic [5:0] ctrl, next_ctrl;
    logic [2:0] irq_status, next_irq_status;
    logic [2:0] irq_mask, next_irq_mask;
    logic [31:0] next_hrdata;
    logic next_irq;
    logic [23:0] odr_cnt, next_odr_cnt;
    logic odr_tick, next_odr_tick;
    logic [PW-1:0] rd_ptr, next_rd_ptr;
    logic [PW-1:0] wr_ptr, next_wr_ptr;
    logic [5:0] count, next_count;
    logic overflow_flag, next_overflow_flag;
    logic watermark_flag, next_watermark_flag;
    logic event_flag, next_event_flag;
    logic [4:0] periods_since_event, next_periods_since_event;
    logic next_queue_src;
    logic mem_we;
    logic refused;
    gyro_fifo_pkg::fifo_mode_t fifo_mode;
    gyro_fifo_pkg::sys_mode_t sys_mode;
    logic [5:0] watermark_level;
    logic [2:0] rate_select_field;
    logic fifo_int_en;
    logic req_rd;
    logic [7:0] req_idx;
    logic wr_ctrl, wr_setup, wr_mask, wr_irq, wr_any;
    logic enter_active;
    logic push, pop;
    logic [7:0] status_now;
    assign fifo_mode = decode_fifo_mode(
        setup[`SETUP_MODE_MSB:`SETUP_MODE_LSB]); // [R6]
    assign watermark_level = setup[`SETUP_WMRK_MSB:0];
    assign sys_mode = decode_sys_mode(ctrl[`CTRL_SYS_MSB:0]);
    assign rate_select_field = ctrl[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
    assign fifo_int_en = ctrl[`CTRL_INT_EN_BIT];
    assign status_now = status_byte(overflow_flag, watermark_flag, count);

    // ---------------------------------------------------------------
    // Bus slave
    // ---------------------------------------------------------------
    assign req_rd = hsel && htrans[1] && hready && !hwrite;
    assign req_idx = haddr[9:2];
    assign wr_any = dphase.valid && dphase.write;
    assign wr_ctrl = wr_any && dphase.idx == `IDX_SYS_CTRL;
    assign wr_setup = wr_any && dphase.idx == `IDX_FIFO_SETUP;
    assign wr_mask = wr_any && dphase.idx == `IDX_IRQ_MASK;
    assign wr_irq = wr_any && dphase.idx == `IDX_IRQ_STATUS;
    assign enter_active = wr_ctrl
        && sys_mode != gyro_fifo_pkg::SYS_ACTIVE
        && hwdata[`CTRL_SYS_MSB]; // [R2]

    always_comb begin
        next_dphase = '{hsel && htrans[1] && hready, hwrite, req_idx};
        next_setup = wr_setup ? hwdata[7:0] : setup;
        next_ctrl = wr_ctrl ? hwdata[5:0] : ctrl;
        next_irq_mask = wr_mask ? hwdata[2:0] : irq_mask;
        next_hrdata = 32'h0000_0000;
        if (req_rd) begin
            unique case (req_idx)
                `IDX_GEN_STATUS: next_hrdata[7:0] = status_now; // [R1]
                `IDX_FIFO_STATUS: next_hrdata[7:0] = status_now; // [R1]
                `IDX_FIFO_SETUP: next_hrdata[7:0] = setup;
                `IDX_FIFO_EVENT: next_hrdata[7:0] =
                    {2'h0, event_flag, periods_since_event};
                `IDX_SYS_CTRL: next_hrdata[5:0] = ctrl;
                `IDX_IRQ_STATUS: next_hrdata[2:0] = irq_status;
                `IDX_IRQ_MASK: next_hrdata[2:0] = irq_mask;
                `IDX_INT_SOURCE:
                    next_hrdata[`INT_QUEUE_INTERRUPT_SOURCE_BIT] = queue_interrupt_source;
                `IDX_OUT_X: next_hrdata[15:0] = mem[rd_ptr].x;
                `IDX_OUT_Y: next_hrdata[15:0] = mem[rd_ptr].y;
                `IDX_OUT_Z: next_hrdata[15:0] = mem[rd_ptr].z;
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            dphase <= '0;
            setup <= `SETUP_RESET;
            ctrl <= `CTRL_RESET;
            irq_mask <= `IRQ_RESET;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'h1;
            hresp <= 1'h0;
        end else begin
            dphase <= next_dphase;
            setup <= next_setup;
            ctrl <= next_ctrl;
            irq_mask <= next_irq_mask;
            hrdata <= next_hrdata;
            hreadyout <= 1'h1;
            hresp <= 1'h0;
        end
    end

    // ---------------------------------------------------------------
    // Output data rate divider
    // ---------------------------------------------------------------
    always_comb begin
        next_odr_cnt = 24'h00_0000;
        next_odr_tick = 1'h0;
        if (sys_mode == gyro_fifo_pkg::SYS_ACTIVE && !enter_active) begin
            if (odr_cnt >= (24'(ODR_BASE_CYCLES) << rate_select_field)
                    - 24'h00_0001) begin
                next_odr_tick = 1'h1; // [R14]
            end else begin
                next_odr_cnt = odr_cnt + 24'h00_0001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            odr_cnt <= 24'h00_0000;
            odr_tick <= 1'h0;
        end else begin
            odr_cnt <= next_odr_cnt;
            odr_tick <= next_odr_tick;
        end
    end

    // ---------------------------------------------------------------
    // FIFO pointers and flags
    // ---------------------------------------------------------------
    // Pop is taken at the Z address phase so the data just read is gone
    assign push = odr_tick && fifo_mode != gyro_fifo_pkg::FIFO_OFF; // [R14]
    assign pop = req_rd && req_idx == `IDX_OUT_Z && count != 6'h00; // [R18]

    always_comb begin
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        next_count = count;
        next_overflow_flag = overflow_flag;
        mem_we = 1'h0;
        refused = 1'h0;
        if (fifo_mode == gyro_fifo_pkg::FIFO_OFF || enter_active) begin
            next_rd_ptr = '0; // [R10] [R2]
            next_wr_ptr = '0;
            next_count = 6'h00;
            next_overflow_flag = 1'h0;
        end else begin
            if (pop) begin
                next_rd_ptr = rd_ptr + PW'(1); // [R18]
                next_count = count - 6'h01;
            end
            if (push) begin
                if (next_count == FULL) begin
                    next_overflow_flag = 1'h1; // [R3]
                    if (fifo_mode == gyro_fifo_pkg::FIFO_CIRCULAR) begin
                        next_rd_ptr = next_rd_ptr + PW'(1); // [R7]
                        next_wr_ptr = wr_ptr + PW'(1);
                        mem_we = 1'h1;
                    end else begin
                        refused = 1'h1; // [R8]
                    end
                end else begin
                    next_wr_ptr = wr_ptr + PW'(1); // [R12]
                    next_count = next_count + 6'h01; // [R5]
                    mem_we = 1'h1;
                end
            end
            if (next_count < FULL) begin
                next_overflow_flag = 1'h0; // [R3]
            end
        end
        // New level, so the flag never lags a setup write
        next_watermark_flag = next_setup[`SETUP_WMRK_MSB:0] != 6'h00
            && next_count >= next_setup[`SETUP_WMRK_MSB:0]; // [R4] [R11]
        next_event_flag = next_overflow_flag
            || next_watermark_flag; // [R15]
        next_periods_since_event = periods_since_event;
        if (!next_event_flag || enter_active) begin
            next_periods_since_event = 5'h00; // [R16]
        end else if (event_flag && odr_tick
                && periods_since_event != `EVENT_TIME_MAX) begin
            next_periods_since_event = periods_since_event + 5'h01; // [R16]
        end
        next_queue_src = next_event_flag && next_ctrl[`CTRL_INT_EN_BIT]; // [R17]
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= 6'h00;
            overflow_flag <= 1'h0;
            watermark_flag <= 1'h0;
            event_flag <= 1'h0;
            periods_since_event <= 5'h00;
            queue_interrupt_source <= 1'h0;
        end else begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count <= next_count;
            overflow_flag <= next_overflow_flag;
            watermark_flag <= next_watermark_flag;
            event_flag <= next_event_flag;
            periods_since_event <= next_periods_since_event;
            queue_interrupt_source <= next_queue_src;
        end
    end

    // Sample storage carries no reset; only pointers give it meaning
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem[wr_ptr] <= sample_in;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt status
    // ---------------------------------------------------------------
    always_comb begin
        logic [2:0] set_bits;
        set_bits = 3'h0;
        set_bits[`IRQ_OVF_BIT] = next_overflow_flag && !overflow_flag;
        set_bits[`IRQ_WMK_BIT] = next_watermark_flag && !watermark_flag;
        set_bits[`IRQ_REFUSED_BIT] = refused;
        // A new event wins over a clear in the same cycle
        next_irq_status = (irq_status & ~(wr_irq ? hwdata[2:0] : 3'h0))
            | set_bits;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_status <= `IRQ_RESET;
            irq <= 1'h0;
        end else begin
            irq_status <= next_irq_status;
            irq <= next_irq;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    logic hold_state;
    assign hold_state = fifo_mode != gyro_fifo_pkg::FIFO_OFF
        && !enter_active && !pop;
    sequence s_full_push;
        push && count == FULL && hold_state;
    endsequence
    sequence s_event_fall;
        event_flag ##1 !event_flag;
    endsequence
    property p_status_mirror;
        req_rd && (req_idx == `IDX_GEN_STATUS
            || req_idx == `IDX_FIFO_STATUS)
            |=> hrdata[7:0] == $past(status_now);
    endproperty
    a_status_mirror: assert property (p_status_mirror) // [R1]
        else $error("status mirror mismatch");
    property p_enter_clear;
        enter_active |=> count == 6'h00 && !overflow_flag
            && periods_since_event == 5'h00;
    endproperty
    a_enter_clear: assert property (p_enter_clear) // [R2]
        else $error("status not cleared on entering active");
    property p_ovf_level;
        count < FULL |-> !overflow_flag;
    endproperty
    a_ovf_level: assert property (p_ovf_level) // [R3]
        else $error("overflow set below full");
    property p_ovf_set;
        s_full_push |=> overflow_flag && count == FULL;
    endproperty
    a_ovf_set: assert property (p_ovf_set) // [R3]
        else $error("overflow not raised on full push");
    property p_watermark;
        watermark_flag == (watermark_level != 6'h00
            && count >= watermark_level);
    endproperty
    a_watermark: assert property (p_watermark) // [R4]
        else $error("watermark flag wrong");
    property p_circular;
        s_full_push and (fifo_mode == gyro_fifo_pkg::FIFO_CIRCULAR)
            |=> rd_ptr == $past(rd_ptr) + PW'(1) && wr_ptr != $past(wr_ptr);
    endproperty
    a_circular: assert property (p_circular) // [R7]
        else $error("circular full push did not replace oldest");
    property p_stop;
        s_full_push and (fifo_mode == gyro_fifo_pkg::FIFO_STOP)
            |=> wr_ptr == $past(wr_ptr) && rd_ptr == $past(rd_ptr);
    endproperty
    a_stop: assert property (p_stop) // [R8]
        else $error("stop mode accepted a sample when full");
    property p_disabled;
        fifo_mode == gyro_fifo_pkg::FIFO_OFF
            |=> count == 6'h00 && !watermark_flag;
    endproperty
    a_disabled: assert property (p_disabled) // [R10]
        else $error("disabled FIFO not emptied");
    property p_event_or;
        event_flag == (overflow_flag || watermark_flag);
    endproperty
    a_event_or: assert property (p_event_or) // [R15]
        else $error("event flag not OR of flags");
    property p_time_reset;
        s_event_fall |-> periods_since_event == 5'h00;
    endproperty
    a_time_reset: assert property (p_time_reset) // [R16]
        else $error("elapsed periods not cleared");
    property p_int_source;
        ##1 queue_interrupt_source == (event_flag && fifo_int_en);
    endproperty
    a_int_source: assert property (p_int_source) // [R17]
        else $error("interrupt source flag wrong");
    property p_pop;
        pop && !push && !enter_active
            && fifo_mode != gyro_fifo_pkg::FIFO_OFF
            |=> count == $past(count) - 6'h01;
    endproperty
    a_pop: assert property (p_pop) // [R18]
        else $error("pop did not decrement count");
    property p_tick_single;
        odr_tick |=> !odr_tick;
    endproperty
    a_tick_single: assert property (p_tick_single) // [R14]
        else $error("rate tick longer than one cycle");

endmodule : gyro_sample_fifo_control

// [rtl/gyro_fifo_cfg.svh]
`ifndef GYRO_FIFO_CFG_SVH
`define GYRO_FIFO_CFG_SVH

// ---------------------------------------------------------------
// Register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define IDX_GEN_STATUS 8'h00
`define IDX_FIFO_STATUS 8'h08
`define IDX_FIFO_SETUP 8'h09
`define IDX_FIFO_EVENT 8'h0A
`define IDX_SYS_CTRL 8'h20
`define IDX_IRQ_STATUS 8'h21
`define IDX_IRQ_MASK 8'h22
`define IDX_INT_SOURCE 8'h23
`define IDX_OUT_X 8'h24
`define IDX_OUT_Y 8'h25
`define IDX_OUT_Z 8'h26

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define STATUS_OVF_BIT 7
`define STATUS_WMK_BIT 6
`define SETUP_MODE_MSB 7
`define SETUP_MODE_LSB 6
`define SETUP_WMRK_MSB 5
`define EVENT_FLAG_BIT 5
`define CTRL_SYS_MSB 1
`define CTRL_RATE_MSB 4
`define CTRL_RATE_LSB 2
`define CTRL_INT_EN_BIT 5
`define INT_QUEUE_INTERRUPT_SOURCE_BIT 2
`define IRQ_OVF_BIT 0
`define IRQ_WMK_BIT 1
`define IRQ_REFUSED_BIT 2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SETUP_RESET 8'h00
`define CTRL_RESET 6'h00
`define IRQ_RESET 3'h0

// ---------------------------------------------------------------
// Sizes and timing
// ---------------------------------------------------------------
`define FIFO_DEPTH 32
`define EVENT_TIME_MAX 5'h1F
`define CLK_HZ 25000000
`define ODR_MAX_HZ 800

`endif

// [rtl/gyro_fifo_pkg.sv]
package gyro_fifo_pkg;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        FIFO_OFF,
        FIFO_CIRCULAR,
        FIFO_STOP
    } fifo_mode_t;

    typedef enum logic [1:0] {
        SYS_STANDBY,
        SYS_READY,
        SYS_ACTIVE
    } sys_mode_t;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } sample_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] idx;
    } bus_phase_t;

endpackage : gyro_fifo_pkg

// [tb/gyro_host_model.sv]
`timescale 1ns/1ps
`include "gyro_fifo_cfg.svh"

// ---------------------------------------------------------------
// Host processor on the register bus
// ---------------------------------------------------------------
module gyro_host_model (
    input wire logic core_clk,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
    end

    // Single word transfer; wait states are tolerated, hready is polled
    task automatic xfer(input logic w, input logic [7:0] idx,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {22'h00_0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, idx, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] q);
        xfer(1'b0, idx, 32'h0000_0000, q);
    endtask : rd

    // Setup only from standby, and always via disabled
    task automatic cfg(input logic [7:0] s);
        wr(`IDX_SYS_CTRL, 32'h0000_0000);
        wr(`IDX_FIFO_SETUP, 32'h0000_0000);
        wr(`IDX_FIFO_SETUP, {24'h00_0000, s});
    endtask : cfg
endmodule : gyro_host_model

// [tb/gyro_sample_fifo_control_tb.sv]
`timescale 1ns/1ps
`include "gyro_fifo_cfg.svh"

module gyro_sample_fifo_control_tb;
    // Short divider keeps a 32-deep fill to a few hundred cycles
    localparam int BASE = 20;
    localparam int LIMIT = 12000;
    logic core_clk, reset, hsel, hwrite, hreadyout, hresp;
    logic queue_interrupt_source, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    gyro_fifo_pkg::sample_t sample_in;
    int errors, tests_run, cycles;

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    gyro_sample_fifo_control #(.DEPTH(32), .ODR_BASE_CYCLES(BASE))
        u_gyro_sample_fifo_control (.core_clk(core_clk), .reset(reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sample_in(sample_in),
        .queue_interrupt_source(queue_interrupt_source), .irq(irq));

    gyro_host_model u_gyro_host_model (.core_clk(core_clk), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

    // ---------------------------------------------------------------
    // Checks and closing
    // ---------------------------------------------------------------
    task automatic chk_reg(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] q;
        u_gyro_host_model.rd(idx, q);
        tests_run++;
        if (q !== e) begin
            errors++;
            $display("[ERR] %0t reg %h read %h want %h", $time, idx, q, e);
        end
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic e, input string s);
        tests_run++;
        if (got !== e) begin
            errors++;
            $display("[ERR] %0t %s is %b want %b", $time, s, got, e);
        end
    endtask : chk_bit

    task automatic results;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("[ERR] %0t run did not finish", $time);
            results();
        end
    end

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        errors = 0;
        tests_run = 0;
        cycles = 0;
        reset = 1'b1;
        sample_in = {16'h1a2b, 16'h3c4d, 16'h5e6f};
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        chk_reg(`IDX_FIFO_STATUS, 32'h0000_0000);
        chk_reg(`IDX_FIFO_SETUP, 32'h0000_0000);
        chk_reg(`IDX_FIFO_EVENT, 32'h0000_0000);
        chk_reg(8'h30, 32'h0000_0000);
        chk_bit(hresp, 1'b0, "hresp");
        // Stop mode, code 11, watermark 4, then a new sample value
        u_gyro_host_model.cfg(8'hc4);
        u_gyro_host_model.wr(`IDX_SYS_CTRL, 32'h0000_0022);
        repeat (40 * BASE) @(posedge core_clk);
        sample_in <= {16'h7a8b, 16'h9cad, 16'hbecf};
        repeat (4 * BASE) @(posedge core_clk);
        u_gyro_host_model.wr(`IDX_SYS_CTRL, 32'h0000_0021);
        chk_reg(`IDX_FIFO_STATUS, 32'h0000_00e0);
        chk_reg(`IDX_GEN_STATUS, 32'h0000_00e0);
        chk_reg(`IDX_FIFO_EVENT, 32'h0000_003f);
        chk_bit(queue_interrupt_source, 1'b1, "fifo source");
        chk_reg(`IDX_INT_SOURCE, 32'h0000_0004);
        chk_reg(`IDX_IRQ_STATUS, 32'h0000_0007);
        chk_bit(irq, 1'b0, "irq masked");
        u_gyro_host_model.wr(`IDX_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        chk_bit(irq, 1'b1, "irq unmasked");
        u_gyro_host_model.wr(`IDX_IRQ_STATUS, 32'h0000_0007);
        repeat (2) @(posedge core_clk);
        chk_bit(irq, 1'b0, "irq cleared");
        chk_reg(`IDX_IRQ_STATUS, 32'h0000_0000);
        chk_reg(`IDX_OUT_X, 32'h0000_1a2b);
        chk_reg(`IDX_OUT_Y, 32'h0000_3c4d);
        chk_reg(`IDX_OUT_Z, 32'h0000_5e6f);
        chk_reg(`IDX_FIFO_STATUS, 32'h0000_005f);
        // Disabling empties the queue; interrupt enable is still on
        u_gyro_host_model.wr(`IDX_SYS_CTRL, 32'h0000_0020);
        u_gyro_host_model.wr(`IDX_FIFO_SETUP, 32'h0000_0000);
        // Queue clears one edge after the mode write lands
        @(posedge core_clk);
        chk_reg(`IDX_FIFO_STATUS, 32'h0000_0000);
        chk_reg(`IDX_FIFO_EVENT, 32'h0000_0000);
        chk_bit(queue_interrupt_source, 1'b0, "fifo source");
        // Circular mode, watermark zero: old samples pushed out
        sample_in <= {16'h1a2b, 16'h3c4d, 16'h5e6f};
        u_gyro_host_model.cfg(8'h40);
        u_gyro_host_model.wr(`IDX_SYS_CTRL, 32'h0000_0002);
        repeat (36 * BASE) @(posedge core_clk);
        sample_in <= {16'h7a8b, 16'h9cad, 16'hbecf};
        repeat (36 * BASE) @(posedge core_clk);
        u_gyro_host_model.wr(`IDX_SYS_CTRL, 32'h0000_0001);
        chk_reg(`IDX_FIFO_STATUS, 32'h0000_00a0);
        chk_bit(queue_interrupt_source, 1'b0, "source off");
        chk_reg(`IDX_OUT_X, 32'h0000_7a8b);
        chk_reg(`IDX_OUT_Y, 32'h0000_9cad);
        chk_reg(`IDX_OUT_Z, 32'h0000_becf);
        // Stop code 10, watermark 3, rate 1: one below, then at it
        u_gyro_host_model.cfg(8'h83);
        u_gyro_host_model.wr(`IDX_SYS_CTRL, 32'h0000_0006);
        repeat (100) @(posedge core_clk);
        u_gyro_host_model.wr(`IDX_SYS_CTRL, 32'h0000_0001);
        chk_reg(`IDX_FIFO_STATUS, 32'h0000_0002);
        u_gyro_host_model.wr(`IDX_SYS_CTRL, 32'h0000_0006);
        repeat (140) @(posedge core_clk);
        u_gyro_host_model.wr(`IDX_SYS_CTRL, 32'h0000_0001);
        chk_reg(`IDX_FIFO_STATUS, 32'h0000_0043);
        chk_reg(`IDX_FIFO_EVENT, 32'h0000_0020);
        // Standby then active wipes status and event
        u_gyro_host_model.wr(`IDX_SYS_CTRL, 32'h0000_0000);
        u_gyro_host_model.wr(`IDX_SYS_CTRL, 32'h0000_0002);
        u_gyro_host_model.wr(`IDX_SYS_CTRL, 32'h0000_0001);
        chk_reg(`IDX_FIFO_STATUS, 32'h0000_0000);
        chk_reg(`IDX_FIFO_EVENT, 32'h0000_0000);
        results();
    end
endmodule : gyro_sample_fifo_control_tb
